//--- shared/grs_pkg.sv
// global reset capture sequencer: constants and types
// assumes one clock (hclk) that also serves as the video timing pixel clock
package grs_pkg;
	localparam logic [7:0] GRS_OFF_CTRL = 8'h00;
	localparam logic [7:0] GRS_OFF_READ = 8'h04;
	localparam logic [7:0] GRS_OFF_SHUT = 8'h08;
	localparam logic [7:0] GRS_OFF_RSTEND = 8'h0c;
	localparam logic [7:0] GRS_OFF_TIMING = 8'h10;
	localparam logic [7:0] GRS_OFF_STATUS = 8'h14;
	// ctrl bit positions
	localparam int GRS_B_TRIG = 0;
	localparam int GRS_B_BULB = 1;
	localparam int GRS_B_STROBE = 2;
	localparam int GRS_B_STREAM = 3;
	localparam int GRS_B_SLAVE = 4;
	// timing register fields
	localparam int GRS_F_SCALE = 0;
	localparam int GRS_F_STRLEN = 16;
	// reset values and strobe length maximum
	localparam logic [4:0] GRS_CTRL_RST = 5'h00;
	localparam logic [15:0] GRS_RSTEND_RST = 16'h3160;
	localparam logic [9:0] GRS_STRLEN_MAX = 10'h3ff;
	localparam logic [15:0] GRS_LINE_RST = 16'h0100;
	// cycle and line counts
	localparam logic [19:0] GRS_STROBE_DLY = 20'h00010;
	localparam int GRS_STROBE_UNIT_LOG2 = 9;
	localparam int GRS_POST_LINES = 2;

	typedef enum {
		GRS_ROLL, GRS_WAIT, GRS_RST, GRS_INT, GRS_BULB, GRS_EXT, GRS_READ, GRS_POST
	} grs_state_t;

	typedef struct packed {
		logic slave;
		logic stream;
		logic strobe_en;
		logic bulb_en;
		logic soft_trig;
	} grs_ctrl_t;

	typedef struct packed {
		logic [7:0] read_hi;
		logic [15:0] read_lo;
		logic [7:0] shut_hi;
		logic [15:0] shut_lo;
		logic [15:0] rst_end;
		logic [1:0] scale;
		logic [9:0] strobe_len;
		logic [15:0] line_len;
	} grs_cfg_t;
endpackage

//--- src/grs_seq.sv
// global reset capture sequencer with ahb-lite register slave
// assumes frame_valid/line_valid come from video timing on hclk
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
module grs_seq (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic general_trigger_input,
	input wire logic frame_valid,
	input wire logic line_valid,
	output logic rolling_shutter_operation,
	output logic all_row_reset_capture,
	output logic integrating,
	output logic readout,
	output logic streaming,
	output logic shutter,
	output logic strobe
);
	function automatic logic [11:0] scale_mult(input logic [1:0] code);
		case (code)
			2'h0: scale_mult = 12'h200;
			2'h1: scale_mult = 12'h800;
			2'h2: scale_mult = 12'h080;
			default: scale_mult = 12'h020;
		endcase
	endfunction

	function automatic logic [23:0] join24(input logic [7:0] hi, input logic [15:0] lo);
		join24 = {hi, lo};
	endfunction

	grs_pkg::grs_ctrl_t ctrl_r;
	grs_pkg::grs_cfg_t cfg_r;
	grs_pkg::grs_state_t st_r;
	logic [2:0] pin_sync_r;
	logic pin_lvl_r;
	logic armed_r;
	logic bulb_r;
	logic strobe_en_r;
	logic [11:0] pre_r;
	logic [23:0] ph_r;
	logic [23:0] seq_r;
	logic [16:0] post_r;
	logic [19:0] str_r;
	logic fv_seen_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] status;
	logic [23:0] read_start;
	logic [23:0] shut_start;
	logic [23:0] int_len;
	logic [23:0] ext_len;
	logic [23:0] ph_target;
	logic tick;
	logic ph_done;
	logic trig_lvl;
	logic [19:0] str_end;
	logic [16:0] post_len;

	////////////////////////////////////////////////////////////////
	// ahb-lite slave
	always_comb begin
		status = 32'h0;
		status[3:0] = 4'(st_r);
		status[4] = streaming;
		status[5] = shutter;
		status[6] = strobe;
		status[7] = armed_r;
		status[8] = pin_lvl_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
		end else begin
			wr_pend_r <= hsel && hready && htrans[1] && hwrite;
			wr_addr_r <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				case (haddr[7:0])
					grs_pkg::GRS_OFF_CTRL: hrdata <= {27'h0, ctrl_r};
					grs_pkg::GRS_OFF_READ: hrdata <= {8'h0, cfg_r.read_hi, cfg_r.read_lo};
					grs_pkg::GRS_OFF_SHUT: hrdata <= {8'h0, cfg_r.shut_hi, cfg_r.shut_lo};
					grs_pkg::GRS_OFF_RSTEND: hrdata <= {16'h0, cfg_r.rst_end};
					grs_pkg::GRS_OFF_TIMING: hrdata <= {6'h0, cfg_r.strobe_len, cfg_r.line_len[13:0], cfg_r.scale};
					grs_pkg::GRS_OFF_STATUS: hrdata <= status;
					default: hrdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= grs_pkg::GRS_CTRL_RST;
			cfg_r <= '0;
			cfg_r.rst_end <= grs_pkg::GRS_RSTEND_RST;
			cfg_r.line_len <= grs_pkg::GRS_LINE_RST;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				grs_pkg::GRS_OFF_CTRL: ctrl_r <= hwdata[4:0];
				grs_pkg::GRS_OFF_READ: {cfg_r.read_hi, cfg_r.read_lo} <= hwdata[23:0];
				grs_pkg::GRS_OFF_SHUT: {cfg_r.shut_hi, cfg_r.shut_lo} <= hwdata[23:0];
				grs_pkg::GRS_OFF_RSTEND: cfg_r.rst_end <= hwdata[15:0];
				grs_pkg::GRS_OFF_TIMING: begin
					cfg_r.scale <= hwdata[grs_pkg::GRS_F_SCALE +: 2];
					cfg_r.strobe_len <= hwdata[grs_pkg::GRS_F_STRLEN +: 10];
					cfg_r.line_len <= {2'h0, hwdata[15:2]};
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// trigger input
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_sync_r <= 3'h0;
			pin_lvl_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], general_trigger_input};
			if (pin_sync_r[2] == pin_sync_r[1])
				pin_lvl_r <= pin_sync_r[1];
		end
	end

	assign trig_lvl = pin_lvl_r | ctrl_r.soft_trig;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			armed_r <= 1'b0;
		else if (st_r == grs_pkg::GRS_ROLL && !trig_lvl)
			armed_r <= 1'b1;
		else if (st_r != grs_pkg::GRS_ROLL)
			armed_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// phase timing
	assign read_start = join24(cfg_r.read_hi, cfg_r.read_lo);
	assign shut_start = join24(cfg_r.shut_hi, cfg_r.shut_lo);
	assign int_len = read_start - shut_start - {8'h0, cfg_r.rst_end};
	assign ext_len = read_start - shut_start;
	assign tick = (pre_r + 12'h1 >= scale_mult(cfg_r.scale));
	assign post_len = 17'(cfg_r.line_len) * 17'(grs_pkg::GRS_POST_LINES) - 17'h1;

	always_comb begin
		case (st_r)
			grs_pkg::GRS_RST: ph_target = {8'h0, cfg_r.rst_end};
			grs_pkg::GRS_INT: ph_target = int_len;
			grs_pkg::GRS_EXT: ph_target = ext_len;
			default: ph_target = 24'h0;
		endcase
	end
	assign ph_done = tick && (ph_r + 24'h1 >= ph_target);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= grs_pkg::GRS_ROLL;
			bulb_r <= 1'b0;
			strobe_en_r <= 1'b0;
			fv_seen_r <= 1'b0;
			post_r <= 17'h0;
		end else begin
			case (st_r)
				grs_pkg::GRS_ROLL: if (armed_r && trig_lvl && streaming) begin
					st_r <= grs_pkg::GRS_WAIT;
					bulb_r <= ctrl_r.bulb_en;
					strobe_en_r <= ctrl_r.strobe_en;
				end
				grs_pkg::GRS_WAIT: if (ctrl_r.slave ? !frame_valid : !line_valid)
					st_r <= grs_pkg::GRS_RST;
				grs_pkg::GRS_RST: if (ph_done)
					st_r <= bulb_r ? grs_pkg::GRS_BULB : grs_pkg::GRS_INT;
				grs_pkg::GRS_INT: if (ph_done)
					st_r <= grs_pkg::GRS_READ;
				grs_pkg::GRS_BULB: if (!trig_lvl)
					st_r <= grs_pkg::GRS_EXT;
				grs_pkg::GRS_EXT: if (ph_done)
					st_r <= grs_pkg::GRS_READ;
				grs_pkg::GRS_READ: begin
					if (frame_valid)
						fv_seen_r <= 1'b1;
					if (fv_seen_r && !frame_valid) begin
						st_r <= grs_pkg::GRS_POST;
						fv_seen_r <= 1'b0;
						post_r <= 17'h0;
					end
				end
				grs_pkg::GRS_POST: begin
					post_r <= post_r + 17'h1;
					if (post_r >= post_len)
						st_r <= grs_pkg::GRS_ROLL;
				end
				default: st_r <= grs_pkg::GRS_ROLL;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_r <= 12'h0;
			ph_r <= 24'h0;
		end else if (ph_done || st_r == grs_pkg::GRS_ROLL || st_r == grs_pkg::GRS_WAIT
				|| (st_r == grs_pkg::GRS_BULB && !trig_lvl)) begin
			// prescaler parked in rolling so a new scale code never meets a stale count
			pre_r <= 12'h0;
			ph_r <= 24'h0;
		end else if (tick) begin
			pre_r <= 12'h0;
			ph_r <= ph_r + 24'h1;
		end else begin
			pre_r <= pre_r + 12'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// shutter and strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_r <= 24'h0;
			shutter <= 1'b0;
		end else if (st_r == grs_pkg::GRS_ROLL || st_r == grs_pkg::GRS_WAIT) begin
			seq_r <= 24'h0;
		end else if (st_r == grs_pkg::GRS_POST && post_r >= post_len) begin
			shutter <= 1'b0;
		end else if (!shutter && st_r != grs_pkg::GRS_POST) begin
			if (tick)
				seq_r <= seq_r + 24'h1;
			if (tick && seq_r + 24'h1 >= shut_start)
				shutter <= 1'b1;
		end
	end

	assign str_end = grs_pkg::GRS_STROBE_DLY + (20'(cfg_r.strobe_len) << grs_pkg::GRS_STROBE_UNIT_LOG2);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			str_r <= 20'h0;
			strobe <= 1'b0;
		end else if (st_r == grs_pkg::GRS_INT || st_r == grs_pkg::GRS_BULB || st_r == grs_pkg::GRS_EXT) begin
			if (str_r != 20'hfffff)
				str_r <= str_r + 20'h1;
			if (strobe_en_r && str_r == grs_pkg::GRS_STROBE_DLY && cfg_r.strobe_len != 10'h0)
				strobe <= 1'b1;
			else if (cfg_r.strobe_len != grs_pkg::GRS_STRLEN_MAX && str_r == str_end)
				strobe <= 1'b0;
		end else begin
			str_r <= 20'h0;
			strobe <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// phase outputs and standby deferral
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rolling_shutter_operation <= 1'b1;
			all_row_reset_capture <= 1'b0;
			integrating <= 1'b0;
			readout <= 1'b0;
			streaming <= 1'b0;
		end else begin
			rolling_shutter_operation <= st_r == grs_pkg::GRS_ROLL || st_r == grs_pkg::GRS_WAIT;
			all_row_reset_capture <= st_r == grs_pkg::GRS_RST;
			integrating <= st_r == grs_pkg::GRS_INT || st_r == grs_pkg::GRS_BULB || st_r == grs_pkg::GRS_EXT;
			readout <= st_r == grs_pkg::GRS_READ;
			if (st_r == grs_pkg::GRS_ROLL)
				streaming <= ctrl_r.stream;
		end
	end

	////////////////////////////////////////////////////////////////
	// assertions
	property p_strobe_max;
		@(posedge hclk) disable iff (!hresetn)
		(strobe && cfg_r.strobe_len == grs_pkg::GRS_STRLEN_MAX && st_r != grs_pkg::GRS_READ) |=> strobe || st_r == grs_pkg::GRS_READ;
	endproperty
	a_strobe_max: assert property (p_strobe_max) else $error("max strobe dropped early");

	property p_bulb_hold;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_BULB && trig_lvl) |=> st_r == grs_pkg::GRS_BULB;
	endproperty
	a_bulb_hold: assert property (p_bulb_hold) else $error("bulb left while trigger held");

	property p_bulb_ext;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_BULB && !trig_lvl) |=> st_r == grs_pkg::GRS_EXT;
	endproperty
	a_bulb_ext: assert property (p_bulb_ext) else $error("no extension after bulb");

	property p_scale;
		@(posedge hclk) disable iff (!hresetn)
		tick |-> pre_r == scale_mult(cfg_r.scale) - 12'h1;
	endproperty
	a_scale: assert property (p_scale) else $error("tick not at scale");

	property p_rearm;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_ROLL && $past(st_r) != grs_pkg::GRS_ROLL && trig_lvl) |=> st_r == grs_pkg::GRS_ROLL;
	endproperty
	a_rearm: assert property (p_rearm) else $error("retrigger without release");

	property p_shut_neg;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_WAIT && $past(st_r) == grs_pkg::GRS_ROLL) |-> !shutter;
	endproperty
	a_shut_neg: assert property (p_shut_neg) else $error("trigger before shutter negation");

	property p_truncate;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_WAIT && !ctrl_r.slave && line_valid) |=> st_r == grs_pkg::GRS_WAIT;
	endproperty
	a_truncate: assert property (p_truncate) else $error("row reset inside a line");

	property p_slave;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_WAIT && ctrl_r.slave && frame_valid) |=> st_r == grs_pkg::GRS_WAIT;
	endproperty
	a_slave: assert property (p_slave) else $error("slave start inside a frame");

	property p_stream;
		@(posedge hclk) disable iff (!hresetn)
		(st_r != grs_pkg::GRS_ROLL && streaming) |=> streaming;
	endproperty
	a_stream: assert property (p_stream) else $error("standby during sequence");

	property p_rows;
		@(posedge hclk) disable iff (!hresetn)
		(st_r == grs_pkg::GRS_RST && ph_done) |=> ##1 integrating && !all_row_reset_capture;
	endproperty
	a_rows: assert property (p_rows) else $error("rows not released");
endmodule

//--- verif/grs_host_model.sv
// far side model: free-running video timing and a trigger pin driver
// assumes hclk doubles as the pixel clock and pin_req comes from the bench
`timescale 1ns/100ps
module grs_host_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic pin_req,
	output logic frame_valid,
	output logic line_valid,
	output logic general_trigger_input
);
	logic [6:0] pos_r;
	////////////////////////////////////////////////////////////////////////
	// 96-cycle frame: four 16-cycle lines, then two blank lines
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pos_r <= 7'h00;
		else
			pos_r <= (pos_r == 7'h5f) ? 7'h00 : pos_r + 7'h01;
	end
	assign frame_valid = pos_r < 7'h40;
	assign line_valid = frame_valid && (pos_r[3:0] < 4'hc);
	////////////////////////////////////////////////////////////////////////
	// pin raised in early blanking only, held until the bench lets go
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			general_trigger_input <= 1'b0;
		else if (!pin_req)
			general_trigger_input <= 1'b0;
		else if (pos_r >= 7'h40 && pos_r < 7'h50)
			general_trigger_input <= 1'b1;
	end
endmodule

//--- verif/testbench.sv
// testbench for the capture sequencer: bus tasks, sequence runs, monitors
// assumes grs_seq as the only bus slave and grs_host_model as video source
`timescale 1ns/100ps
module testbench;
	typedef struct {int rr; int integ; int tol; int strb; int shut; logic fv;} grs_tb_exp_t;
	logic hclk, hresetn, hsel, hwrite, pin_req, trig_pin, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, w;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic frame_valid, line_valid, rolling_shutter_operation, all_row_reset_capture;
	logic integrating, readout, streaming, shutter, strobe, rr_p, shut_p, rd_p, fv_at, rdp;
	int fails, checks, seed, rr_w, int_w, strb_w, cnt_rr, shut_d, cnt_pc;
	grs_tb_exp_t q_run[$];
	grs_tb_exp_t e;
	logic [31:0] q_rd[$];
	grs_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .general_trigger_input(trig_pin), .frame_valid(frame_valid),
		.line_valid(line_valid), .rolling_shutter_operation(rolling_shutter_operation),
		.all_row_reset_capture(all_row_reset_capture), .integrating(integrating), .readout(readout),
		.streaming(streaming), .shutter(shutter), .strobe(strobe));
	grs_host_model host (.hclk(hclk), .hresetn(hresetn), .pin_req(pin_req), .frame_valid(frame_valid),
		.line_valid(line_valid), .general_trigger_input(trig_pin));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_int(input int got, input int exp, input int tol);
		checks++;
		if (got > exp + tol || got < exp - tol) begin
			fails++;
			$display("mismatch at %0t: count %0d, expected %0d", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	function automatic int mult(input logic [1:0] sc);
		case (sc)
			2'h0: return 512;
			2'h1: return 2048;
			2'h2: return 128;
			default: return 32;
		endcase
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return rolling_shutter_operation;
			1: return integrating;
			2: return readout;
			default: return frame_valid;
		endcase
	endfunction
	task automatic wait_sig(input int k, input logic v);
		int n;
		n = 0;
		while (sig(k) !== v && n < 40000) begin
			@(negedge hclk);
			n++;
		end
		if (n >= 40000) begin
			fails++;
			complete_run();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// single ahb-lite transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		q_rd.push_back(exp);
		bus(1'b0, a, 32'h00000000);
	endtask
	always @(posedge hclk) begin
		if (rdp && hreadyout === 1'b1) begin
			chk_word(hrdata, q_rd.pop_front());
			chk_bit(hresp, 1'b0);
		end
		rdp = hsel && htrans[1] && !hwrite && hreadyout;
	end
	////////////////////////////////////////////////////////////////////////
	// one capture: note expectations, trigger by bit or pin, then rearm
	task automatic run(input logic [1:0] sc, input int rs, input logic [9:0] sl, input logic [4:0] c,
		input int hold, input logic stby);
		int m;
		grs_tb_exp_t x;
		m = mult(sc);
		bus(1'b1, grs_pkg::GRS_OFF_TIMING, {6'h00, sl, 14'h0004, sc});
		bus(1'b1, grs_pkg::GRS_OFF_READ, 32'(rs));
		x.rr = 2 * m;
		// row-reset flag lags the state by one clock, shutter does not
		x.shut = 3 * m - 1;
		x.fv = (hold == 0) && !c[4];
		x.integ = (hold > 0) ? hold + (rs - 3) * m + 3 : (rs - 5) * m;
		x.tol = (hold > 0) ? 6 : 0;
		x.strb = !c[2] ? 0 : ((sl == 10'h3ff) ? x.integ - 16 : int'(sl) * 512);
		q_run.push_back(x);
		if (hold > 0) begin
			bus(1'b1, grs_pkg::GRS_OFF_CTRL, {27'h0000000, c});
			pin_req <= 1'b1;
			wait_sig(1, 1'b1);
			repeat (hold) @(posedge hclk);
			pin_req <= 1'b0;
		end else begin
			wait_sig(3, 1'b0);
			wait_sig(3, 1'b1);
			bus(1'b1, grs_pkg::GRS_OFF_CTRL, {27'h0000000, c} | 32'h1);
		end
		if (stby) begin
			wait_sig(1, 1'b1);
			bus(1'b1, grs_pkg::GRS_OFF_CTRL, 32'h00000001);
			wait_sig(2, 1'b1);
			chk_bit(streaming, 1'b1);
		end
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		repeat (150) @(negedge hclk);
		chk_bit(rolling_shutter_operation, 1'b1);
		if (stby)
			chk_bit(streaming, 1'b0);
		bus(1'b1, grs_pkg::GRS_OFF_CTRL, 32'h00000008);
	endtask
	////////////////////////////////////////////////////////////////////////
	// phase monitor: measures each capture and compares at shutter release
	always @(negedge hclk) begin
		if (all_row_reset_capture === 1'b1 && !rr_p) begin
			cnt_rr = 0;
			fv_at = frame_valid;
		end else
			cnt_rr++;
		if (shutter === 1'b1 && !shut_p)
			shut_d = cnt_rr;
		if (readout !== 1'b1 && rd_p)
			cnt_pc = 0;
		else
			cnt_pc++;
		rr_w += (all_row_reset_capture === 1'b1) ? 1 : 0;
		int_w += (integrating === 1'b1) ? 1 : 0;
		strb_w += (strobe === 1'b1) ? 1 : 0;
		if (shutter !== 1'b1 && shut_p) begin
			e = q_run.pop_front();
			chk_int(rr_w, e.rr, 0);
			chk_int(int_w, e.integ, e.tol);
			chk_int(strb_w, e.strb, 0);
			chk_int(shut_d, e.shut, 0);
			chk_int(cnt_pc, 8, 2);
			chk_bit(fv_at, e.fv);
			rr_w = 0;
			int_w = 0;
			strb_w = 0;
		end
		rr_p = (all_row_reset_capture === 1'b1);
		shut_p = (shutter === 1'b1);
		rd_p = (readout === 1'b1);
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hf2b330a8;
		{hsel, hwrite, pin_req, haddr, hwdata, htrans, hsize} = '0;
		{rr_p, shut_p, rd_p, fv_at, rdp, fails, checks, rr_w, int_w, strb_w, cnt_rr, shut_d, cnt_pc} = '0;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		chk_bit(rolling_shutter_operation, 1'b1);
		chk_bit(shutter | strobe, 1'b0);
		rd(grs_pkg::GRS_OFF_RSTEND, 32'h00003160);
		rd(8'h18, 32'h00000000);
		w = $random(seed);
		bus(1'b1, grs_pkg::GRS_OFF_SHUT, w);
		rd(grs_pkg::GRS_OFF_SHUT, w & 32'h00ffffff);
		bus(1'b1, grs_pkg::GRS_OFF_SHUT, 32'h00000003);
		bus(1'b1, grs_pkg::GRS_OFF_RSTEND, 32'h00000002);
		bus(1'b1, grs_pkg::GRS_OFF_CTRL, 32'h00000008);
		rd(grs_pkg::GRS_OFF_STATUS, 32'h00000090);
		run(2'h0, 6, 10'h3ff, 5'h0c, 0, 1'b0);
		run(2'h1, 6, 10'h000, 5'h08, 0, 1'b1);
		run(2'h2, 6, 10'h000, 5'h18, 0, 1'b0);
		run(2'h3, 22, 10'h001, 5'h0c, 0, 1'b0);
		run(2'h3, 4, 10'h000, 5'h0e, 80 + ($random(seed) & 31), 1'b0);
		complete_run();
	end
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
